/* host_mem_model.sv */
// Host memory model: block base registers and control block contents
`timescale 1ns/1ns
`include "port_state_defines.svh"
module host_mem_model (
  // Function the host placed in the control block
  input  wire logic        sel_mode,
  // Base registers and fetched function contents
  output logic [15:0] block_base_low_reg,
  output logic [15:0] block_base_high_reg,
  output logic [7:0]  func_code,
  output logic [15:0] func_data,
  output logic [7:0]  tx_ring_len_in,
  output logic [7:0]  rx_ring_len_in
);
  // Control block base split over two registers, written before the fetch
  assign block_base_low_reg  = 16'h4c20;
  assign block_base_high_reg = 16'h0003;
  // Ring format or mode function; ring counts come from the data block
  assign func_code      = sel_mode ? `FUNC_WRITE_MODE : `FUNC_WRITE_RING;
  assign func_data      = sel_mode ? 16'h8001 : 16'h1230;
  assign tx_ring_len_in = 8'h10;
  assign rx_ring_len_in = 8'h20;
endmodule

/* port_state_ctrl.sv */
// Port state controller: selftest, reset, init handshake, start and stop
`timescale 1ns/1ns
`include "port_state_defines.svh"

module port_state_ctrl
  import port_state_pkg::*;
#(
  parameter int ST_CYCLES = 64
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Host register writes to register zero
  input  wire logic        cmd_wr,
  input  wire logic [3:0]  cmd_code,
  input  wire logic        reset_bit_wr,
  input  wire logic        intr_enable_wr,
  input  wire logic        intr_enable_val,
  input  wire logic        done_clear_wr,
  input  wire logic        bus_init_pin,
  // Host block base registers two and three
  input  wire logic [15:0] block_base_low_reg,
  input  wire logic [15:0] block_base_high_reg,
  // Function fetched from the control block
  input  wire logic [7:0]  func_code,
  input  wire logic [15:0] func_data,
  input  wire logic [7:0]  tx_ring_len_in,
  input  wire logic [7:0]  rx_ring_len_in,
  input  wire logic [47:0] factory_addr,
  // Selftest result and network side
  input  wire logic        selftest_fail,
  input  wire logic [1:0]  selftest_kind,
  input  wire logic [7:0]  selftest_code,
  input  wire logic        tx_busy,
  input  wire logic        frame_counted,
  // Status back to the host
  output logic [2:0]       port_state,
  output logic             done_intr,
  output logic             intr_enable,
  output logic [7:0]       port_error_status_reg_one,
  output logic [7:0]       edge_leds,
  output logic [31:0]      control_block_base,
  output logic [7:0]       tx_ring_len,
  output logic [7:0]       rx_ring_len,
  output logic [15:0]      mode_reg,
  output logic [15:0]      frame_counter,
  output logic [47:0]      station_addr,
  output logic             multicast_empty,
  output logic             receive_enable,
  output logic             maint_frames_enable,
  output logic             transmit_go
);

  // All module state in one record.
  // Everything the host can see is a field here, so that every output
  // leaves a flop and no decode glitch can reach the host side.
  // The visible copies cost a few flops more than decoding the state
  // at the pins, but their timing matches the state change exactly.
  typedef struct packed {
    port_state_t st;
    logic        done;
    logic        ie;
    logic [7:0]  err;
    logic [7:0]  leds;
    logic [31:0] base;
    logic [7:0]  txl;
    logic [7:0]  rxl;
    logic [15:0] mode;
    logic [15:0] cnt;
    logic [47:0] addr;
    logic        mc_empty;
    logic        last_fail;
    logic [15:0] tcnt;
    logic        stop_pend;
    logic        tx_go;
    logic        init_s1;
    logic        init_s2;
    logic [7:0]  err_vis;   // Error code as the host reads it
    logic        rx_en;     // Frame reception allowed
    logic        maint_en;  // Maintenance frames allowed
  } ctrl_t;

  ctrl_t cur;       // Registered state
  ctrl_t next_cur;  // Next state

  logic  done_set;  // Event that sets the done flag this cycle
  logic  do_reset;  // Reset request from host bit or bus init

  // Next-state logic.
  // Order of precedence inside one cycle:
  //   1. A reset request (host bit or synchronised bus init) wins
  //      over any command written in the same cycle.
  //   2. In ready or running, a pending stop is settled first; new
  //      commands are ignored while the last frame drains.
  //   3. The done flag is set by an accepted fetch, start, poll, stop or halt command, cleared by
  //      the host's write of one; a set in the same cycle wins so
  //      that an acknowledge is never lost.
  // The visible copies of status are worked out last, from the next
  // state, so they change on the same edge as the state itself.
  // Limitation: the selftest is modelled by a fixed run time and the
  // result inputs are only looked at on its last cycle.
  always_comb begin
    next_cur = cur;
    done_set = 1'b0;
    next_cur.tx_go   = 1'b0;
    // Bus init is a pin: two flops before use
    next_cur.init_s1 = bus_init_pin;
    next_cur.init_s2 = cur.init_s1;
    do_reset = reset_bit_wr || cur.init_s2;
    if (intr_enable_wr) begin
      next_cur.ie = intr_enable_val;
    end
    if (frame_counted && cur.st == st_running) begin
      next_cur.cnt = cur.cnt + 16'd1;                // Running keeps all
    end
    if (do_reset) begin
      next_cur.st = st_reset;
    end else begin
      unique case (cur.st)
        st_reset: begin
          // Clear configuration and flags on the edge that leaves reset; LEDs are kept
          next_cur.txl      = `RING_LEN_RESET;
          next_cur.rxl      = `RING_LEN_RESET;
          next_cur.mode     = `MODE_RESET;
          next_cur.cnt      = 16'h0000;
          next_cur.addr     = factory_addr;
          next_cur.mc_empty = 1'b1;
          next_cur.base     = 32'h0000_0000;
          next_cur.done     = 1'b0;
          next_cur.ie       = 1'b0;
          next_cur.stop_pend = 1'b0;
          // A previous failure or power-up forces selftest
          if (cur.last_fail) begin
            next_cur.st   = st_selftest;
            next_cur.tcnt = 16'h0000;
          end else begin
            next_cur.err  = `ERR_NONE;
            next_cur.st   = st_ready;
          end
        end
        st_selftest: begin
          // Fixed run time stands in for the diagnostic
          next_cur.tcnt = cur.tcnt + 16'd1;
          if (cur.tcnt == 16'(ST_CYCLES - 1)) begin
            next_cur.last_fail = selftest_fail;
            if (!selftest_fail) begin
              next_cur.err  = `ERR_NONE;
              next_cur.leds = 8'h00;
              next_cur.st   = st_ready;
            end else begin
              next_cur.leds = selftest_code;
              next_cur.err  = selftest_code;
              unique case (selftest_kind)
                `FAIL_DMA: next_cur.st = st_bus_halted;
                `FAIL_NET: begin
                  next_cur.st   = st_net_halted;
                  next_cur.cnt  = 16'h0000;          // Counter and mode cleared
                  next_cur.mode = `MODE_RESET;
                end
                default:   next_cur.st = st_both_halted;
              endcase
            end
          end
        end
        st_ready, st_running: begin
          // Commands; ready/running keep stored data
          if (cur.stop_pend && !tx_busy) begin
            next_cur.stop_pend = 1'b0;
            next_cur.st        = st_ready;           // Frame finished
          end else if (cmd_wr && !cur.stop_pend) begin
            unique case (cmd_code)
              `CMD_FETCH_BASE: begin
                next_cur.base = {block_base_high_reg, block_base_low_reg};
                done_set = 1'b1;
              end
              `CMD_FETCH_FUNC: begin
                // Execute the fetched function
                if (func_code == `FUNC_WRITE_RING) begin
                  next_cur.txl = tx_ring_len_in;
                  next_cur.rxl = rx_ring_len_in;
                end else if (func_code == `FUNC_WRITE_MODE) begin
                  next_cur.mode = func_data;
                end else if (func_code == `FUNC_CLEAR_CNT) begin
                  next_cur.cnt = 16'h0000;
                end
                done_set = 1'b1;
              end
              `CMD_START: begin
                if (cur.st == st_ready) begin
                  next_cur.st = st_running;          // Keeps all
                end
                done_set = 1'b1;
              end
              `CMD_POLL: begin
                next_cur.tx_go = (cur.st == st_running);
                done_set = 1'b1;
              end
              `CMD_STOP: begin
                // Let an in-flight frame finish first
                if (cur.st == st_running) begin
                  if (tx_busy) begin
                    next_cur.stop_pend = 1'b1;
                  end else begin
                    next_cur.st = st_ready;
                  end
                end
                done_set = 1'b1;
              end
              `CMD_HALT: begin
                next_cur.st = st_port_halted;
                done_set = 1'b1;
              end
              `CMD_SELFTEST: begin
                next_cur.st   = st_selftest;
                next_cur.tcnt = 16'h0000;
              end
              default: begin
              end
            endcase
          end
        end
        // Halted states leave only through reset
        st_port_halted, st_bus_halted, st_net_halted, st_both_halted: begin
        end
      endcase
    end
    // Set wins over the clear
    if (done_set) begin
      next_cur.done = 1'b1;
    end else if (done_clear_wr) begin
      next_cur.done = 1'b0;
    end
    // Visible copies, taken from the next state so outputs are flops
    next_cur.rx_en    = (next_cur.st == st_running);
    next_cur.maint_en = (next_cur.st == st_ready) || (next_cur.st == st_running);
    // Bus-halted reads as zero: no status shown
    if (next_cur.st == st_bus_halted || next_cur.st == st_both_halted) begin
      next_cur.err_vis = 8'h00;
    end else begin
      next_cur.err_vis = next_cur.err;
    end
  end

  // State register; power-up enters reset with selftest pending
  // Clearing the whole record also gives the right visible copies for
  // the reset state: no reception, no maintenance frames, no error.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur           <= '0;
      cur.st        <= st_reset;
      cur.last_fail <= 1'b1;
      cur.mc_empty  <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state record
  assign port_state         = cur.st;
  assign done_intr          = cur.done;
  assign intr_enable        = cur.ie;
  assign edge_leds          = cur.leds;
  assign control_block_base = cur.base;
  assign tx_ring_len        = cur.txl;
  assign rx_ring_len        = cur.rxl;
  assign mode_reg           = cur.mode;
  assign frame_counter      = cur.cnt;
  assign station_addr       = cur.addr;
  assign multicast_empty    = cur.mc_empty;
  assign transmit_go        = cur.tx_go;
  // Status copies registered with the state
  assign port_error_status_reg_one = cur.err_vis;
  assign receive_enable            = cur.rx_en;
  assign maint_frames_enable       = cur.maint_en;

endmodule

/* port_state_defines.svh */
// Constants for the port state controller: codes, reset values, timing counts
`ifndef PORT_STATE_DEFINES_SVH
`define PORT_STATE_DEFINES_SVH
`define CMD_NOP          4'h0
`define CMD_FETCH_BASE   4'h1
`define CMD_FETCH_FUNC   4'h2
`define CMD_SELFTEST     4'h3
`define CMD_START        4'h4
`define CMD_POLL         4'h5
`define CMD_HALT         4'h7
`define CMD_STOP         4'hf
`define FUNC_WRITE_RING  8'h0a
`define FUNC_WRITE_MODE  8'h0e
`define FUNC_CLEAR_CNT   8'h0c
`define FUNC_WRITE_PHYS  8'h05
`define ERR_NONE         8'h00
`define MODE_RESET       16'h0000
`define RING_LEN_RESET   8'h00
`define SELFTEST_CYCLES  16'd64
`define FAIL_DMA         2'd1
`define FAIL_NET         2'd2
`define FAIL_OTHER       2'd3
`endif

/* port_state_pkg.sv */
// Types shared by the port state controller
package port_state_pkg;
  typedef enum logic [2:0] {
    st_reset, st_selftest, st_ready, st_running,
    st_port_halted, st_bus_halted, st_net_halted, st_both_halted
  } port_state_t;
endpackage

/* psc_checker.sv */
// Assertion checker for the port state controller ports
`timescale 1ns/1ns
`include "port_state_defines.svh"
module psc_checker
  import port_state_pkg::*;
(
  // Inputs and outputs watched, grouped to save space
  input wire logic core_clk, rst_b, cmd_wr, reset_bit_wr, done_clear_wr, tx_busy,
  input wire logic [3:0] cmd_code,
  input wire logic [15:0] block_base_low_reg, block_base_high_reg, mode_reg, frame_counter,
  input wire logic [47:0] factory_addr, station_addr,
  input wire logic [2:0] port_state,
  input wire logic done_intr, transmit_go, multicast_empty, intr_enable,
  input wire logic [31:0] control_block_base,
  input wire logic [7:0] tx_ring_len, rx_ring_len
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Command accepted only in ready or running, no host reset bit write racing it
  wire live = cmd_wr && !reset_bit_wr && (port_state == st_ready || port_state == st_running);
  property p_base; live && port_state == st_ready && cmd_code == `CMD_FETCH_BASE |=> done_intr &&
    control_block_base == {$past(block_base_high_reg), $past(block_base_low_reg)}; endproperty
  a_base: assert property (p_base) else $error("base fetch wrong");
  property p_clr; done_clear_wr && !cmd_wr && !tx_busy |=> !done_intr; endproperty
  a_clr: assert property (p_clr) else $error("done not cleared");
  property p_start; live && port_state == st_ready && cmd_code == `CMD_START |=> port_state == st_running && done_intr;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_poll; transmit_go |-> $past(cmd_wr && cmd_code == `CMD_POLL && port_state == st_running); endproperty
  a_poll: assert property (p_poll) else $error("transmit without poll");
  property p_halt; live && cmd_code == `CMD_HALT |=> port_state == st_port_halted; endproperty
  a_halt: assert property (p_halt) else $error("halt not taken");
  property p_rst; reset_bit_wr |=> port_state == st_reset; endproperty
  a_rst: assert property (p_rst) else $error("reset bit ignored");
  property p_clean; $past(port_state) == st_reset && port_state == st_ready |-> station_addr == factory_addr &&
    multicast_empty && tx_ring_len == 0 && rx_ring_len == 0 && mode_reg == 0 && frame_counter == 0 && !done_intr;
  endproperty
  a_clean: assert property (p_clean) else $error("reset values wrong");
  property p_bush; $past(port_state) == st_bus_halted && port_state != st_bus_halted |-> port_state == st_reset;
  endproperty
  a_bush: assert property (p_bush) else $error("bus halted left wrongly");
  property p_run; port_state == st_running && $past(port_state) == st_running && !$past(cmd_wr) |->
    $stable(station_addr) && $stable(tx_ring_len) && $stable(mode_reg); endproperty
  a_run: assert property (p_run) else $error("running lost state");
endmodule
bind port_state_ctrl psc_checker i_chk (.*);

/* testbench.sv */
// Self-checking testbench for the port state controller
`timescale 1ns/1ns
`include "port_state_defines.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module testbench
  import port_state_pkg::*;
;
  logic core_clk, rst_b, cmd_wr, reset_bit_wr, intr_enable_wr, intr_enable_val, done_clear_wr, bus_init_pin;
  logic selftest_fail, tx_busy, frame_counted, sel_mode, done_intr, intr_enable, multicast_empty;
  logic receive_enable, maint_frames_enable, transmit_go;
  logic [3:0] cmd_code;
  logic [1:0] selftest_kind;
  logic [2:0] port_state;
  logic [7:0] selftest_code, func_code, tx_ring_len_in, rx_ring_len_in, tx_ring_len, rx_ring_len;
  logic [7:0] edge_leds, port_error_status_reg_one;
  logic [15:0] block_base_low_reg, block_base_high_reg, func_data, mode_reg, frame_counter;
  logic [31:0] control_block_base;
  logic [47:0] station_addr;
  logic [47:0] factory_addr = 48'h0a0b0c0d0e0f; // Arbitrary default address
  int errors, samples_checked, cycles;
  port_state_ctrl #(.ST_CYCLES(4)) i_dut (.*);
  host_mem_model i_host (.*);
  // Free-running clock, 8 ns period
  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic tick(int n = 1); repeat (n) @(negedge core_clk); endtask
  // Port command write, one cycle strobe
  task automatic cmd(logic [3:0] c); cmd_wr = 1; cmd_code = c; tick(); cmd_wr = 0; endtask
  // Write one to the done bit
  task automatic clr(); done_clear_wr = 1; tick(); done_clear_wr = 0; `CHK("done", 1'b0, done_intr) endtask
  task automatic wait_st(logic [2:0] s);
    for (int i = 0; i < 200 && port_state !== s; i++) tick();
    `CHK("port_state", s, port_state)
  endtask
  // Values restored by every reset
  task automatic chk_clean();
    `CHK("station", factory_addr, station_addr)
    `CHK("mcast", 1'b1, multicast_empty)
    `CHK("rings", 16'h0000, {tx_ring_len, rx_ring_len})
    `CHK("mode", 16'h0000, mode_reg)
    `CHK("count", 16'h0000, frame_counter)
    `CHK("maint", 1'b1, maint_frames_enable)
  endtask
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, far above the hundred or so cycles needed
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    {cmd_wr, cmd_code, reset_bit_wr, intr_enable_wr, intr_enable_val, done_clear_wr, bus_init_pin} = '0;
    {selftest_fail, selftest_kind, selftest_code, tx_busy, frame_counted, sel_mode} = '0;
    rst_b = 0;
    repeat (16) @(posedge core_clk);
    tick();
    rst_b = 1;
    wait_st(st_ready);
    chk_clean();
    $display("power-up test done");
    intr_enable_wr = 1; intr_enable_val = 1; tick(); intr_enable_wr = 0;
    `CHK("intr_en", 1'b1, intr_enable)
    cmd(`CMD_FETCH_BASE); `CHK("done", 1'b1, done_intr)
    `CHK("base", {block_base_high_reg, block_base_low_reg}, control_block_base)
    clr();
    cmd(`CMD_FETCH_FUNC); `CHK("done", 1'b1, done_intr)
    `CHK("rings", 16'h1020, {tx_ring_len, rx_ring_len})
    clr(); sel_mode = 1;
    cmd(`CMD_FETCH_FUNC); `CHK("mode", 16'h8001, mode_reg)
    clr();
    cmd(`CMD_POLL); `CHK("tx_go", 1'b0, transmit_go)
    // Receive buffers are owned by the adapter before this start
    cmd(`CMD_START); `CHK("state", st_running, port_state)
    `CHK("done", 1'b1, done_intr)
    `CHK("rx_en", 1'b1, receive_enable)
    clr();
    cmd(`CMD_POLL); `CHK("tx_go", 1'b1, transmit_go)
    clr(); frame_counted = 1; tick(); frame_counted = 0;
    $display("init and start test done");
    tx_busy = 1; cmd(`CMD_STOP); tick(3);
    `CHK("state", st_running, port_state)
    tx_busy = 0; wait_st(st_ready);
    `CHK("rx_en", 1'b0, receive_enable)
    tick(); clr();
    cmd(`CMD_START); `CHK("rings", 16'h1020, {tx_ring_len, rx_ring_len})
    `CHK("mode", 16'h8001, mode_reg)
    `CHK("count", 16'h0001, frame_counter)
    clr();
    cmd(`CMD_HALT); `CHK("state", st_port_halted, port_state)
    cmd(`CMD_START); `CHK("state", st_port_halted, port_state)
    `CHK("count", 16'h0001, frame_counter)
    $display("stop and halt test done");
    reset_bit_wr = 1; tick(); reset_bit_wr = 0;
    `CHK("state", st_reset, port_state)
    tick(); `CHK("state", st_ready, port_state)
    chk_clean();
    `CHK("intr_en", 1'b0, intr_enable)
    for (int k = 1; k < 4; k++) begin
      selftest_fail = 1; selftest_kind = 2'(k); selftest_code = 8'(8'h50 + k);
      cmd(`CMD_SELFTEST); wait_st(k == 1 ? st_bus_halted : k == 2 ? st_net_halted : st_both_halted);
      `CHK("leds", selftest_code, edge_leds)
      `CHK("err", k == 2 ? selftest_code : 8'h00, port_error_status_reg_one)
      cmd(`CMD_START); `CHK("state", k == 1 ? st_bus_halted : k == 2 ? st_net_halted : st_both_halted, port_state)
      selftest_fail = 0;
      if (k == 2) reset_bit_wr = 1; else bus_init_pin = 1;
      tick(); {reset_bit_wr, bus_init_pin} = '0;
      wait_st(st_selftest);
      wait_st(st_ready);
    end
    $display("selftest and reset test done");
    finish_test();
  end
endmodule
